// [rtl/rtcaf_regs.svh]
`ifndef RTCAF_REGS_SVH
`define RTCAF_REGS_SVH

// register byte offsets
`define RTCAF_TIME_OFS 8'h00
`define RTCAF_DATE_OFS 8'h04
`define RTCAF_ALM0_A_OFS 8'h08
`define RTCAF_ALM0_B_OFS 8'h0c
`define RTCAF_ALM1_A_OFS 8'h10
`define RTCAF_ALM1_B_OFS 8'h14
`define RTCAF_INT_CTRL_OFS 8'h18
`define RTCAF_STATUS_OFS 8'h1c
`define RTCAF_CLEAR_OFS 8'h20
`define RTCAF_IRQ_EN_OFS 8'h24

// interrupt control fields
`define RTCAF_FREQ_SEL_LSB 0
`define RTCAF_FREQ_SEL_MSB 1
`define RTCAF_PIN_EN0_BIT 2
`define RTCAF_PIN_EN1_BIT 3
`define RTCAF_REPEAT0_BIT 4
`define RTCAF_REPEAT1_BIT 5
`define RTCAF_INT_CTRL_W 6
`define RTCAF_INT_CTRL_RST 6'h00

// status / event bits
`define RTCAF_EV_ALARM0 0
`define RTCAF_EV_ALARM1 1
`define RTCAF_EV_NV_DONE 2
`define RTCAF_EV_SECOND 3
`define RTCAF_EV_W 4
`define RTCAF_ALARM_FLAGS 4'h3
`define RTCAF_IRQ_EN_RST 4'h0

// calendar reset values (bcd)
`define RTCAF_SEC_RST 8'h00
`define RTCAF_MIN_RST 8'h00
`define RTCAF_HOUR_RST 8'h00
`define RTCAF_DATE_RST 8'h01
`define RTCAF_MONTH_RST 8'h01
`define RTCAF_YEAR_RST 8'h00
`define RTCAF_DOW_RST 8'h00

// timing
`define RTCAF_PRESC_W 15
`define RTCAF_TAP_4096HZ 2
`define RTCAF_TAP_1HZ 14
`define RTCAF_NV_WRITE_MS 20
`define RTCAF_CLK_MHZ 200

`endif

// [rtl/rtcaf_pkg.sv]
package rtcaf_pkg;

	typedef struct packed {
		logic [7:0] dow;
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] date;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} rtcaf_cal_t;

	// bit 7 of each byte enables the compare of that field
	typedef struct packed {
		logic [7:0] dow;
		logic [7:0] month;
		logic [7:0] date;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} rtcaf_alarm_t;

	typedef enum logic [1:0] {
		RTCAF_NV_IDLE = 2'b01,
		RTCAF_NV_BUSY = 2'b10
	} rtcaf_nv_state_t;

	typedef enum logic [1:0] {
		RTCAF_FO_IRQ = 2'h0,
		RTCAF_FO_1HZ = 2'h1,
		RTCAF_FO_4096HZ = 2'h2,
		RTCAF_FO_32KHZ = 2'h3
	} rtcaf_freq_sel_t;

endpackage

// [rtl/rtcaf_bcd_step.sv]
`timescale 1ns/100ps
module rtcaf_bcd_step (
	input wire logic [7:0] cur,
	input wire logic [7:0] lo,
	input wire logic [7:0] hi,
	input wire logic inc,
	output logic [7:0] nxt,
	output logic wrap
);
	always_comb
	begin
		nxt = cur;
		wrap = 1'b0;
		if (inc)
		begin
			// >= also recovers from out-of-range values written by software
			if (cur >= hi)
			begin
				nxt = lo;
				wrap = 1'b1;
			end
			else if (cur[3:0] >= 4'h9)
				nxt = {cur[7:4] + 4'h1, 4'h0};
			else
				nxt = {cur[7:4], cur[3:0] + 4'h1};
		end
	end
endmodule

// [rtl/rtcaf_top.sv]
// Behaviour
// RQ1: non-volatile writes complete by a self-timed 20 ms cycle; host waits it out.
// RQ2: hours, minutes, seconds, date, month, year, weekday kept as separate fields.
// RQ3: calendar runs correctly to 2099 with automatic leap days.
// RQ4: two independent alarms match any chosen combination of calendar fields; the alarms have no year field, so year cannot be matched.
// RQ5: alarm events show as status flags and may drive the interrupt pin.
// RQ6: repeat mode lets a matched alarm recur instead of firing once.
// RQ7: shared pin can emit 1 Hz, 4096 Hz, 32768 Hz or stay inactive.
// RQ8: frequency-select field of interrupt control chooses interrupt or clock function.
// RQ9: interrupt function pulls the pin low open-drain, otherwise released.
// RQ10: clock function emits a divided crystal clock through open-drain drive.
// RQ11: serial clock input is always sampled, never gated off.
// RQ12: serial data pin drives only low, open-drain, wire-OR safe.
// RQ13: time base divides the 32.768 kHz crystal down to one-second ticks.
// RQ14: a matching alarm sets its status flag to one.
// RQ15: status read clears only alarm flags set when the read began.
// RQ16: time and calendar are held in BCD, seconds and minutes 00 to 59.
// RQ17: alarms are compared once per second tick, one event per matching second.
// RQ18: in interrupt function the pin stays asserted until the flag is cleared.
`timescale 1ns/100ps
`include "rtcaf_regs.svh"
module rtcaf_top #(
	parameter int unsigned NV_WRITE_CYCLES = `RTCAF_NV_WRITE_MS * 1000 * `RTCAF_CLK_MHZ,
	parameter int unsigned PRESC_W = `RTCAF_PRESC_W
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	output logic irq,
	input wire logic crystal_input,
	output logic crystal_output,
	input wire logic serial_clock,
	input wire logic serial_data_i,
	output logic serial_data_o,
	output logic serial_data_oe,
	output logic alarm_or_freq_pin_o,
	output logic alarm_or_freq_pin_oe
);
	localparam int NV_W = $clog2(NV_WRITE_CYCLES + 1);
	localparam logic [NV_W-1:0] NV_LAST = NV_W'(NV_WRITE_CYCLES - 1);

	// ---------------- pin synchronisers
	logic [2:0] sync1_ff;
	logic [2:0] sync2_ff;
	logic xtal_prev_ff;
	logic xtal_s;
	logic scl_s;
	logic sda_s;
	logic xtal_rise;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync1_ff <= 3'h0;
			sync2_ff <= 3'h0;
			xtal_prev_ff <= 1'b0;
		end
		else
		begin
			sync1_ff <= {serial_data_i, serial_clock, crystal_input}; // see RQ11
			sync2_ff <= sync1_ff;
			xtal_prev_ff <= sync2_ff[0];
		end
	end

	assign xtal_s = sync2_ff[0];
	assign scl_s = sync2_ff[1];
	assign sda_s = sync2_ff[2];
	assign xtal_rise = xtal_s & ~xtal_prev_ff;

	// device never drives serial data high and has no protocol engine here
	assign serial_data_o = 1'b0; // see RQ12
	assign serial_data_oe = 1'b0; // see RQ12
	assign alarm_or_freq_pin_o = 1'b0; // see RQ9, RQ10

	// ---------------- apb decode
	logic setup;
	logic access;
	logic [9:0] hit;
	logic mapped;
	logic nv_hit;
	logic nv_busy;
	logic bad;
	logic [31:0] rd_data;
	logic pslverr_ff;
	logic [31:0] prdata_ff;
	logic wr_ok;
	logic rd_status_done;
	logic [`RTCAF_EV_W-1:0] snap_ff;

	rtcaf_pkg::rtcaf_cal_t cal_ff;
	rtcaf_pkg::rtcaf_alarm_t alm_ff [2];
	logic [`RTCAF_INT_CTRL_W-1:0] int_ctrl_ff;
	logic [`RTCAF_EV_W-1:0] stat_ff;
	logic [`RTCAF_EV_W-1:0] irq_en_ff;

	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign pready = 1'b1;
	assign prdata = prdata_ff;
	assign pslverr = pslverr_ff;

	always_comb
	begin
		hit = 10'h000;
		if (paddr == `RTCAF_TIME_OFS)
			hit[0] = 1'b1;
		else if (paddr == `RTCAF_DATE_OFS)
			hit[1] = 1'b1;
		else if (paddr == `RTCAF_ALM0_A_OFS)
			hit[2] = 1'b1;
		else if (paddr == `RTCAF_ALM0_B_OFS)
			hit[3] = 1'b1;
		else if (paddr == `RTCAF_ALM1_A_OFS)
			hit[4] = 1'b1;
		else if (paddr == `RTCAF_ALM1_B_OFS)
			hit[5] = 1'b1;
		else if (paddr == `RTCAF_INT_CTRL_OFS)
			hit[6] = 1'b1;
		else if (paddr == `RTCAF_STATUS_OFS)
			hit[7] = 1'b1;
		else if (paddr == `RTCAF_CLEAR_OFS)
			hit[8] = 1'b1;
		else if (paddr == `RTCAF_IRQ_EN_OFS)
			hit[9] = 1'b1;
	end

	assign mapped = |hit;
	assign nv_hit = |hit[6:2];
	// writes to status, or to a non-volatile register mid-cycle, are refused
	assign bad = ~mapped | (pwrite & hit[7]) | (pwrite & nv_hit & nv_busy); // see RQ1

	always_comb
	begin
		rd_data = 32'h0000_0000;
		if (hit[0])
			rd_data = {8'h00, cal_ff.hour, cal_ff.min, cal_ff.sec}; // see RQ2
		else if (hit[1])
			rd_data = {cal_ff.dow, cal_ff.year, cal_ff.month, cal_ff.date}; // see RQ2
		else if (hit[2])
			rd_data = {alm_ff[0].date, alm_ff[0].hour, alm_ff[0].min, alm_ff[0].sec};
		else if (hit[3])
			rd_data = {16'h0000, alm_ff[0].dow, alm_ff[0].month};
		else if (hit[4])
			rd_data = {alm_ff[1].date, alm_ff[1].hour, alm_ff[1].min, alm_ff[1].sec};
		else if (hit[5])
			rd_data = {16'h0000, alm_ff[1].dow, alm_ff[1].month};
		else if (hit[6])
			rd_data = {26'h0000000, int_ctrl_ff};
		else if (hit[7])
			rd_data = {21'h000000, sda_s, scl_s, nv_busy, 4'h0, stat_ff}; // see RQ5
		else if (hit[9])
			rd_data = {28'h0000000, irq_en_ff};
	end

	// read data and error are captured in setup so access sees flop outputs
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			prdata_ff <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
			snap_ff <= 4'h0;
		end
		else if (setup)
		begin
			prdata_ff <= pwrite ? 32'h0000_0000 : rd_data;
			pslverr_ff <= bad;
			snap_ff <= stat_ff & `RTCAF_ALARM_FLAGS; // see RQ15
		end
	end

	assign wr_ok = access & pwrite & ~pslverr_ff;
	assign rd_status_done = access & ~pwrite & hit[7];

	// ---------------- time base
	// narrower prescaler only to shorten the second in simulation; 3 bits at least
	logic [PRESC_W-1:0] presc_ff;
	logic tick;
	logic tick_d_ff;
	logic time_wr;

	assign time_wr = wr_ok & (hit[0] | hit[1]);
	assign tick = xtal_rise & (&presc_ff); // see RQ13

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			presc_ff <= '0;
		else if (time_wr)
			presc_ff <= '0;
		else if (xtal_rise)
			presc_ff <= presc_ff + 1'b1; // see RQ13
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			tick_d_ff <= 1'b0;
		else
			tick_d_ff <= tick;
	end

	// ---------------- calendar
	rtcaf_pkg::rtcaf_cal_t nxt_cal;
	logic w_sec;
	logic w_min;
	logic w_hour;
	logic w_date;
	logic w_month;
	logic leap;
	logic [7:0] days;

	// bcd year divisible by four: even tens with 0/4/8, odd tens with 2/6
	always_comb
	begin
		if (cal_ff.year[4])
			leap = (cal_ff.year[3:0] == 4'h2) | (cal_ff.year[3:0] == 4'h6);
		else
			leap = (cal_ff.year[3:0] == 4'h0) | (cal_ff.year[3:0] == 4'h4)
				| (cal_ff.year[3:0] == 4'h8);
	end

	always_comb
	begin
		if (cal_ff.month == 8'h02)
			days = leap ? 8'h29 : 8'h28; // see RQ3
		else if ((cal_ff.month == 8'h04) | (cal_ff.month == 8'h06)
			| (cal_ff.month == 8'h09) | (cal_ff.month == 8'h11))
			days = 8'h30;
		else
			days = 8'h31;
	end

	rtcaf_bcd_step u_sec (.cur(cal_ff.sec), .lo(8'h00), .hi(8'h59), .inc(tick),
		.nxt(nxt_cal.sec), .wrap(w_sec)); // see RQ16
	rtcaf_bcd_step u_min (.cur(cal_ff.min), .lo(8'h00), .hi(8'h59), .inc(w_sec),
		.nxt(nxt_cal.min), .wrap(w_min)); // see RQ16
	rtcaf_bcd_step u_hour (.cur(cal_ff.hour), .lo(8'h00), .hi(8'h23), .inc(w_min),
		.nxt(nxt_cal.hour), .wrap(w_hour));
	rtcaf_bcd_step u_date (.cur(cal_ff.date), .lo(8'h01), .hi(days), .inc(w_hour),
		.nxt(nxt_cal.date), .wrap(w_date)); // see RQ3
	rtcaf_bcd_step u_month (.cur(cal_ff.month), .lo(8'h01), .hi(8'h12), .inc(w_date),
		.nxt(nxt_cal.month), .wrap(w_month));
	rtcaf_bcd_step u_year (.cur(cal_ff.year), .lo(8'h00), .hi(8'h99), .inc(w_month),
		.nxt(nxt_cal.year), .wrap());
	rtcaf_bcd_step u_dow (.cur(cal_ff.dow), .lo(8'h00), .hi(8'h06), .inc(w_hour),
		.nxt(nxt_cal.dow), .wrap());

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			cal_ff <= {`RTCAF_DOW_RST, `RTCAF_YEAR_RST, `RTCAF_MONTH_RST, `RTCAF_DATE_RST,
				`RTCAF_HOUR_RST, `RTCAF_MIN_RST, `RTCAF_SEC_RST};
		else if (wr_ok & hit[0])
		begin
			cal_ff.hour <= pwdata[23:16];
			cal_ff.min <= pwdata[15:8];
			cal_ff.sec <= pwdata[7:0];
		end
		else if (wr_ok & hit[1])
		begin
			cal_ff.dow <= {5'h00, pwdata[26:24]};
			cal_ff.year <= pwdata[23:16];
			cal_ff.month <= pwdata[15:8];
			cal_ff.date <= pwdata[7:0];
		end
		else
			cal_ff <= nxt_cal; // see RQ2
	end

	// ---------------- non-volatile write cycle
	rtcaf_pkg::rtcaf_nv_state_t nv_state_ff;
	logic [NV_W-1:0] nv_cnt_ff;
	logic [4:0] pend_sel_ff;
	logic [31:0] pend_data_ff;
	logic commit;

	assign nv_busy = (nv_state_ff == rtcaf_pkg::RTCAF_NV_BUSY);
	assign commit = nv_busy & (nv_cnt_ff == NV_LAST); // see RQ1

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			nv_state_ff <= rtcaf_pkg::RTCAF_NV_IDLE;
			nv_cnt_ff <= '0;
			pend_sel_ff <= 5'h00;
			pend_data_ff <= 32'h0000_0000;
		end
		else
		begin
			case (nv_state_ff)
				rtcaf_pkg::RTCAF_NV_IDLE:
				begin
					if (wr_ok & nv_hit)
					begin
						// staged data lands only when the cycle ends
						pend_sel_ff <= hit[6:2];
						pend_data_ff <= pwdata;
						nv_cnt_ff <= '0;
						nv_state_ff <= rtcaf_pkg::RTCAF_NV_BUSY;
					end
				end
				rtcaf_pkg::RTCAF_NV_BUSY:
				begin
					nv_cnt_ff <= nv_cnt_ff + 1'b1; // see RQ1
					if (commit)
						nv_state_ff <= rtcaf_pkg::RTCAF_NV_IDLE;
				end
				default:
					nv_state_ff <= rtcaf_pkg::RTCAF_NV_IDLE;
			endcase
		end
	end

	// ---------------- alarms
	logic [1:0] armed_ff;
	logic [1:0] fire;
	logic [1:0] repeat_en;

	function automatic logic fmatch(input logic [7:0] a, input logic [7:0] v);
		fmatch = ~a[7] | (a[6:0] == v[6:0]);
	endfunction

	assign repeat_en = {int_ctrl_ff[`RTCAF_REPEAT1_BIT], int_ctrl_ff[`RTCAF_REPEAT0_BIT]};

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			alm_ff[0] <= '0;
			alm_ff[1] <= '0;
			int_ctrl_ff <= `RTCAF_INT_CTRL_RST;
		end
		else if (commit)
		begin
			if (pend_sel_ff[0])
				{alm_ff[0].date, alm_ff[0].hour, alm_ff[0].min, alm_ff[0].sec} <= pend_data_ff;
			if (pend_sel_ff[1])
				{alm_ff[0].dow, alm_ff[0].month} <= pend_data_ff[15:0];
			if (pend_sel_ff[2])
				{alm_ff[1].date, alm_ff[1].hour, alm_ff[1].min, alm_ff[1].sec} <= pend_data_ff;
			if (pend_sel_ff[3])
				{alm_ff[1].dow, alm_ff[1].month} <= pend_data_ff[15:0];
			if (pend_sel_ff[4])
				int_ctrl_ff <= pend_data_ff[`RTCAF_INT_CTRL_W-1:0];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_alarm
			logic any_en;
			logic all_eq;
			assign any_en = alm_ff[gi].sec[7] | alm_ff[gi].min[7] | alm_ff[gi].hour[7]
				| alm_ff[gi].date[7] | alm_ff[gi].month[7] | alm_ff[gi].dow[7];
			assign all_eq = fmatch(alm_ff[gi].sec, cal_ff.sec) // see RQ4
				& fmatch(alm_ff[gi].min, cal_ff.min)
				& fmatch(alm_ff[gi].hour, cal_ff.hour)
				& fmatch(alm_ff[gi].date, cal_ff.date)
				& fmatch(alm_ff[gi].month, cal_ff.month)
				& fmatch(alm_ff[gi].dow, cal_ff.dow);
			// compared once, right after the second has advanced
			assign fire[gi] = tick_d_ff & armed_ff[gi] & any_en & all_eq; // see RQ17
		end
	endgenerate

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			armed_ff <= 2'b00;
		else
		begin
			// a one-shot alarm disarms itself until it is reprogrammed
			armed_ff <= armed_ff & ~(fire & ~repeat_en); // see RQ6
			if (commit & (pend_sel_ff[0] | pend_sel_ff[1]))
				armed_ff[0] <= 1'b1;
			if (commit & (pend_sel_ff[2] | pend_sel_ff[3]))
				armed_ff[1] <= 1'b1;
		end
	end

	// ---------------- status, clear, interrupt enable
	logic [`RTCAF_EV_W-1:0] ev;
	logic [`RTCAF_EV_W-1:0] clr;
	logic [`RTCAF_EV_W-1:0] nxt_stat;

	assign ev = {tick, commit, fire}; // see RQ14
	assign clr = ((wr_ok & hit[8]) ? pwdata[`RTCAF_EV_W-1:0] : 4'h0)
		| (rd_status_done ? snap_ff : 4'h0); // see RQ15
	assign nxt_stat = (stat_ff & ~clr) | ev; // see RQ15

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stat_ff <= 4'h0;
			irq_en_ff <= `RTCAF_IRQ_EN_RST;
		end
		else
		begin
			stat_ff <= nxt_stat; // see RQ5
			if (wr_ok & hit[9])
				irq_en_ff <= pwdata[`RTCAF_EV_W-1:0];
		end
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			irq <= 1'b0;
		else
			irq <= |(stat_ff & irq_en_ff);
	end

	// ---------------- shared pin
	rtcaf_pkg::rtcaf_freq_sel_t fsel;
	logic pin_irq;
	logic nxt_pin_oe;

	assign fsel = rtcaf_pkg::rtcaf_freq_sel_t'(
		int_ctrl_ff[`RTCAF_FREQ_SEL_MSB:`RTCAF_FREQ_SEL_LSB]); // see RQ8
	assign pin_irq = (stat_ff[`RTCAF_EV_ALARM0] & int_ctrl_ff[`RTCAF_PIN_EN0_BIT])
		| (stat_ff[`RTCAF_EV_ALARM1] & int_ctrl_ff[`RTCAF_PIN_EN1_BIT]); // see RQ18

	always_comb
	begin
		case (fsel)
			rtcaf_pkg::RTCAF_FO_1HZ:
				nxt_pin_oe = ~presc_ff[PRESC_W-1]; // see RQ7, RQ10
			rtcaf_pkg::RTCAF_FO_4096HZ:
				nxt_pin_oe = ~presc_ff[`RTCAF_TAP_4096HZ]; // see RQ7, RQ10
			rtcaf_pkg::RTCAF_FO_32KHZ:
				nxt_pin_oe = ~xtal_s; // see RQ7, RQ10
			default:
				nxt_pin_oe = pin_irq; // see RQ9, RQ5
		endcase
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			alarm_or_freq_pin_oe <= 1'b0;
			crystal_output <= 1'b0;
		end
		else
		begin
			alarm_or_freq_pin_oe <= nxt_pin_oe;
			// inverting amplifier stand-in; only meant to drive the crystal
			crystal_output <= ~xtal_s;
		end
	end

endmodule

// [sim/rtcaf_chk.sv]
`timescale 1ns/100ps
`include "rtcaf_regs.svh"
module rtcaf_chk #(
	parameter int unsigned NV_WRITE_CYCLES = `RTCAF_NV_WRITE_MS * 1000 * `RTCAF_CLK_MHZ
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic irq,
	input wire logic crystal_input,
	input wire logic crystal_output,
	input wire logic serial_clock,
	input wire logic serial_data_i,
	input wire logic serial_data_o,
	input wire logic serial_data_oe,
	input wire logic alarm_or_freq_pin_o,
	input wire logic alarm_or_freq_pin_oe
);
	logic [1:0] mode_ff;
	logic [1:0] pend_ff;
	int unsigned nv_cnt_ff;
	logic acc_ok;
	logic nv_adr;
	assign acc_ok = psel && penable && pwrite && pready && !pslverr;
	assign nv_adr = paddr >= `RTCAF_ALM0_A_OFS && paddr <= `RTCAF_INT_CTRL_OFS;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			nv_cnt_ff <= 0;
		else if (acc_ok && nv_adr)
			nv_cnt_ff <= NV_WRITE_CYCLES;
		else if (nv_cnt_ff != 0)
			nv_cnt_ff <= nv_cnt_ff - 1;
	end
	// pin mode is staged and only goes live when the nv cycle ends
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pend_ff <= 2'h0;
			mode_ff <= 2'h0;
		end
		else
		begin
			if (acc_ok && paddr == `RTCAF_INT_CTRL_OFS)
				pend_ff <= pwdata[1:0];
			if (nv_cnt_ff == 1)
				mode_ff <= pend_ff;
		end
	end
	sequence s_setup(logic w, logic [7:0] a);
		psel && !penable && pwrite == w && paddr == a;
	endsequence
	a_pready_high: assert property (pready) else $error("pready low");
	a_unmapped_err: assert property (s_setup(1'b0, 8'h28) |=> pslverr && prdata == 32'h0)
		else $error("unmapped read not refused");
	a_status_ro: assert property (s_setup(1'b1, `RTCAF_STATUS_OFS) |=> pslverr)
		else $error("status write not refused");
	a_clear_reads_zero: assert property (s_setup(1'b0, `RTCAF_CLEAR_OFS) |=> !pslverr && prdata == 32'h0)
		else $error("clear read not zero");
	a_nv_busy_err: assert property (psel && !penable && pwrite && nv_adr && nv_cnt_ff > 2 |=> pslverr)
		else $error("write during nv cycle accepted");
	a_sda_no_drive: assert property (!serial_data_oe && !serial_data_o)
		else $error("serial data driven");
	a_pin_open_drain: assert property (!alarm_or_freq_pin_o)
		else $error("pin driven high");
	a_xtal_hi: assert property (crystal_input [*5] |-> !crystal_output)
		else $error("crystal output not inverted");
	a_xtal_lo: assert property (!crystal_input [*5] |-> crystal_output)
		else $error("crystal output not inverted");
	a_fo_follows: assert property ((mode_ff == 2'h3 && crystal_input) [*5] |-> !alarm_or_freq_pin_oe)
		else $error("pin not following crystal");
	a_irq_masked: assert property (acc_ok && paddr == `RTCAF_IRQ_EN_OFS && pwdata[3:0] == 4'h0 |-> ##[1:2] !irq)
		else $error("irq not masked");
endmodule
bind rtcaf_top rtcaf_chk #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) rtcaf_chk_inst (.clock(clock),
	.rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
	.crystal_input(crystal_input), .crystal_output(crystal_output),
	.serial_clock(serial_clock), .serial_data_i(serial_data_i), .serial_data_o(serial_data_o),
	.serial_data_oe(serial_data_oe), .alarm_or_freq_pin_o(alarm_or_freq_pin_o),
	.alarm_or_freq_pin_oe(alarm_or_freq_pin_oe));

// [sim/rtcaf_far_end.sv]
`timescale 1ns/100ps
module rtcaf_far_end (
	input wire logic scl_low,
	input wire logic sda_low,
	input wire logic sda_oe,
	output logic crystal_input,
	output logic serial_clock,
	output logic serial_data
);
	// crystal runs free, phase unrelated to the system clock
	initial
	begin
		crystal_input = 1'b0;
		#37;
		forever #62.5 crystal_input = ~crystal_input;
	end
	// pulled-up lines: either party can only pull low
	assign serial_clock = !scl_low;
	assign serial_data = !(sda_low || sda_oe);
endmodule

// [sim/testbench.sv]
`timescale 1ns/100ps
`include "rtcaf_regs.svh"
module testbench;
	logic clock, rst_b, psel, penable, pwrite, pready, pslverr, irq, xi, xo;
	logic scl, sda, sdo, sdoe, pin_o, pin_oe, scl_low, sda_low, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;
	int k, c, cx;
	logic po, px;
	logic [7:0] s;
	logic [7:0] ra [4] = '{`RTCAF_INT_CTRL_OFS, `RTCAF_IRQ_EN_OFS, `RTCAF_TIME_OFS, `RTCAF_DATE_OFS};
	logic [31:0] rv [4] = '{32'h0, 32'h0, 32'h0, 32'h101};
	int win [4] = '{1000, 1000, 1600, 1000};
	int lo [4] = '{0, 2, 7, 39};
	int hi [4] = '{0, 3, 9, 41};
	// 4-bit prescaler: one second is 16 crystal rises
	rtcaf_top #(.NV_WRITE_CYCLES(20), .PRESC_W(4)) rtcaf_top_inst (.clock(clock), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready),
		.prdata(prdata), .pslverr(pslverr), .irq(irq), .crystal_input(xi),
		.crystal_output(xo), .serial_clock(scl), .serial_data_i(sda), .serial_data_o(sdo),
		.serial_data_oe(sdoe), .alarm_or_freq_pin_o(pin_o), .alarm_or_freq_pin_oe(pin_oe));
	rtcaf_far_end rtcaf_far_end_inst (.scl_low(scl_low), .sda_low(sda_low), .sda_oe(sdoe),
		.crystal_input(xi), .serial_clock(scl), .serial_data(sda));
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// host side must sit out the whole self-timed write before relying on it
	task nv_wait;
		k = 0;
		do begin apb(1'b0, `RTCAF_STATUS_OFS, 32'h0); k++; end while (q[2] !== 1'b1 && k < 60);
		check("nv_busy", q[8], 1'b0);
		check("nv_done", q[2], 1'b1);
		apb(1'b1, `RTCAF_CLEAR_OFS, 32'h4);
	endtask
	// polls the time word until the seconds move on
	task sec_wait;
		apb(1'b0, `RTCAF_TIME_OFS, 32'h0);
		s = q[7:0];
		k = 0;
		do begin apb(1'b0, `RTCAF_TIME_OFS, 32'h0); k++; end while (q[7:0] === s && k < 200);
		repeat (2) @(posedge clock);
	endtask
	task irq_is(input logic exp);
		repeat (2) @(posedge clock);
		check("irq", irq, exp);
	endtask
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_fail++;
			close_out();
		end
	end
	initial
	begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		scl_low = 1'b0;
		sda_low = 1'b0;
		repeat (4) @(posedge clock);
		rst_b <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b0, ra[i], 32'h0);
			check("reset_value", q, rv[i]);
		end
		apb(1'b0, `RTCAF_STATUS_OFS, 32'h0);
		check("status_reset", q & 32'h10f, 32'h0);
		apb(1'b1, `RTCAF_TIME_OFS, 32'h00235959);
		apb(1'b1, `RTCAF_DATE_OFS, 32'h03991231);
		apb(1'b0, `RTCAF_TIME_OFS, 32'h0);
		check("time", q, 32'h00235959);
		apb(1'b0, `RTCAF_DATE_OFS, 32'h0);
		check("date", q, 32'h03991231);
		sec_wait();
		check("rollover_time", q, 32'h0);
		apb(1'b0, `RTCAF_DATE_OFS, 32'h0);
		check("rollover_date", q, 32'h04000101);
		apb(1'b1, `RTCAF_TIME_OFS, 32'h00235959);
		apb(1'b1, `RTCAF_DATE_OFS, 32'h00040228);
		sec_wait();
		apb(1'b0, `RTCAF_DATE_OFS, 32'h0);
		check("leap_day", q, 32'h01040229);
		apb(1'b0, 8'h28, 32'h0);
		check("unmapped_err", e, 1'b1);
		apb(1'b1, `RTCAF_STATUS_OFS, 32'hf);
		check("status_wr_err", e, 1'b1);
		apb(1'b0, `RTCAF_CLEAR_OFS, 32'h0);
		check("clear_read", {e, q[30:0]}, 32'h0);
		apb(1'b1, `RTCAF_ALM0_A_OFS, 32'h80000000);
		check("nv_accept", e, 1'b0);
		apb(1'b0, `RTCAF_STATUS_OFS, 32'h0);
		check("nv_busy_now", q[8], 1'b1);
		apb(1'b1, `RTCAF_INT_CTRL_OFS, 32'h3);
		check("busy_refuse", e, 1'b1);
		nv_wait();
		check("nv_polls", k >= 4, 1'b1);
		apb(1'b0, `RTCAF_ALM0_A_OFS, 32'h0);
		check("alm0_a", q, 32'h80000000);
		apb(1'b1, `RTCAF_ALM0_B_OFS, 32'h0);
		nv_wait();
		apb(1'b1, `RTCAF_IRQ_EN_OFS, 32'h4);
		irq_is(1'b0);
		apb(1'b1, `RTCAF_ALM1_B_OFS, 32'h00008181);
		nv_wait();
		apb(1'b0, `RTCAF_ALM1_B_OFS, 32'h0);
		check("alm1_b", q, 32'h00008181);
		apb(1'b1, `RTCAF_ALM1_A_OFS, 32'h0);
		k = 0;
		do begin apb(1'b0, `RTCAF_STATUS_OFS, 32'h0); k++; end while (q[2] !== 1'b1 && k < 60);
		irq_is(1'b1);
		apb(1'b0, `RTCAF_STATUS_OFS, 32'h0);
		check("done_kept", q[2], 1'b1);
		apb(1'b1, `RTCAF_IRQ_EN_OFS, 32'h0);
		irq_is(1'b0);
		apb(1'b1, `RTCAF_IRQ_EN_OFS, 32'h4);
		irq_is(1'b1);
		apb(1'b1, `RTCAF_CLEAR_OFS, 32'h4);
		irq_is(1'b0);
		for (int m = 0; m < 4; m++)
		begin
			apb(1'b1, `RTCAF_INT_CTRL_OFS, 32'h3c | m);
			nv_wait();
			apb(1'b0, `RTCAF_INT_CTRL_OFS, 32'h0);
			check("int_ctrl", q, 32'h3c | m);
			c = 0;
			cx = 0;
			po = pin_oe;
			px = xo;
			repeat (win[m])
			begin
				@(posedge clock);
				#1;
				c += (pin_oe === 1'b1 && po === 1'b0);
				cx += (xo === 1'b1 && px === 1'b0);
				po = pin_oe;
				px = xo;
			end
			check("pin_edges", c >= lo[m] && c <= hi[m], 1'b1);
		end
		check("xtal_edges", cx >= 39 && cx <= 41, 1'b1);
		// alarm 0 one-shot on pin, alarm 1 repeating, both on minute 00
		apb(1'b1, `RTCAF_INT_CTRL_OFS, 32'h24);
		nv_wait();
		apb(1'b1, `RTCAF_ALM1_B_OFS, 32'h0);
		nv_wait();
		apb(1'b1, `RTCAF_ALM1_A_OFS, 32'h00008000);
		nv_wait();
		apb(1'b1, `RTCAF_TIME_OFS, 32'h00000006);
		apb(1'b1, `RTCAF_ALM0_A_OFS, 32'h00008000);
		nv_wait();
		apb(1'b1, `RTCAF_CLEAR_OFS, 32'hf);
		sec_wait();
		check("alarm_sec", q, 32'h00000007);
		check("pin_irq", pin_oe, 1'b1);
		apb(1'b0, `RTCAF_STATUS_OFS, 32'h0);
		check("alarm_flags", q[1:0], 2'b11);
		repeat (2) @(posedge clock);
		check("pin_release", pin_oe, 1'b0);
		apb(1'b0, `RTCAF_STATUS_OFS, 32'h0);
		check("read_cleared", q[1:0], 2'b00);
		sec_wait();
		check("pin_masked", pin_oe, 1'b0);
		apb(1'b0, `RTCAF_STATUS_OFS, 32'h0);
		check("repeat_only", q[1:0], 2'b10);
		scl_low <= 1'b1;
		repeat (4) @(posedge clock);
		apb(1'b0, `RTCAF_STATUS_OFS, 32'h0);
		check("lines", q[10:9], 2'b10);
		scl_low <= 1'b0;
		sda_low <= 1'b1;
		repeat (4) @(posedge clock);
		apb(1'b0, `RTCAF_STATUS_OFS, 32'h0);
		check("lines", q[10:9], 2'b01);
		close_out();
	end
endmodule
